// File: rtl/rgmii_phy_port.sv
// Gray-pointer crossing queue and the PHY-side RGMII data port with its line pair map.
`timescale 1ns/1ps

// Small crossing queue; each side keeps its own pointer state and syncs the far gray pointer.
module cdc_word_queue #(
	parameter int WIDTH  = 10,
	parameter int ADDR_W = rgmii_phy_pkg::CDC_ADDR_W
) (
	input  wire logic             wr_clk,
	input  wire logic             wr_rst,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_clk,
	input  wire logic             rd_rst,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data
);
	// Pointer state of one side: binary, gray and the two-stage copy of the far gray pointer.
	typedef struct packed {
		logic [ADDR_W:0] bin;
		logic [ADDR_W:0] gray;
		logic [ADDR_W:0] far_s1;
		logic [ADDR_W:0] far_s2;
	} side_t;

	side_t            wr_q;                 // Write side state.
	side_t            wr_d;                 // Its next value.
	side_t            rd_q;                 // Read side state.
	side_t            rd_d;                 // Its next value.
	logic [WIDTH-1:0] mem [2**ADDR_W];      // Storage words, written on the write clock only.

	// Binary to gray, so that only one pointer bit moves per step across the crossing.
	function automatic logic [ADDR_W:0] to_gray(input logic [ADDR_W:0] b);
		return b ^ (b >> 1);
	endfunction

	// Full when the write pointer is one lap ahead; empty when the pointers match.
	assign wr_ready = wr_q.gray != {~wr_q.far_s2[ADDR_W -: 2], wr_q.far_s2[ADDR_W-2:0]};
	assign rd_valid = rd_q.gray != rd_q.far_s2;
	assign rd_data  = mem[rd_q.bin[ADDR_W-1:0]];

	// Write side next state; the first sync stage feeds only the second.
	always_comb begin
		wr_d        = wr_q;
		wr_d.far_s1 = rd_q.gray;
		wr_d.far_s2 = wr_q.far_s1;
		if (wr_valid && wr_ready) begin
			wr_d.bin  = wr_q.bin + 1'b1;
			wr_d.gray = to_gray(wr_d.bin);
		end
		if (wr_rst) begin
			wr_d = '0;
		end
	end

	// Read side next state.
	always_comb begin
		rd_d        = rd_q;
		rd_d.far_s1 = wr_q.gray;
		rd_d.far_s2 = rd_q.far_s1;
		if (rd_valid && rd_ready) begin
			rd_d.bin  = rd_q.bin + 1'b1;
			rd_d.gray = to_gray(rd_d.bin);
		end
		if (rd_rst) begin
			rd_d = '0;
		end
	end

	// Write side registers and storage.
	always_ff @(posedge wr_clk) begin
		wr_q <= wr_d;
		if (wr_valid && wr_ready) begin
			mem[wr_q.bin[ADDR_W-1:0]] <= wr_data;
		end
	end

	// Read side registers.
	always_ff @(posedge rd_clk) begin
		rd_q <= rd_d;
	end
endmodule

// PHY data port: RGMII beats on the MAC transmit clock, line pair map on the core clock.
module rgmii_phy_port (
	input  wire logic                        clk,
	input  wire logic                        srst,
	input  wire logic                        tx_clk,
	input  wire rgmii_phy_pkg::rgmii_tx_t    rgmii_tx,
	output rgmii_phy_pkg::rgmii_rx_t         rgmii_rx,
	input  wire rgmii_phy_pkg::line_status_t line_status,
	input  wire logic                        mdi_x,
	input  wire rgmii_phy_pkg::frame_byte_t  rx_in,
	input  wire logic                        rx_in_valid,
	output logic                             rx_in_ready,
	output rgmii_phy_pkg::frame_byte_t       tx_out,
	output logic                             tx_out_valid,
	output logic                             tx_overrun,
	output rgmii_phy_pkg::line_pairs_t       line_pair_out,
	output rgmii_phy_pkg::line_pairs_t       line_pair_oe_n,
	input  wire rgmii_phy_pkg::line_pairs_t  line_pair_in,
	output rgmii_phy_pkg::line_pairs_t       line_rx,
	output logic [3:0]                       pair_tx_used,
	output logic [3:0]                       pair_rx_used,
	input  wire logic                        ref_osc_in,
	output logic                             ref_osc_out
);
	localparam int WORD_W = $bits(rgmii_phy_pkg::frame_byte_t);

	// All state on the MAC transmit clock.
	typedef struct packed {
		logic                        rst_s1;   // Reset sync, first stage.
		logic                        rst_s2;   // Reset sync, second stage; the link reset.
		rgmii_phy_pkg::line_status_t stat_s1;  // Status sync, first stage.
		rgmii_phy_pkg::line_status_t stat_s2;  // Status sync, second stage.
		logic                        half;     // Receive: high nibble of a slow word is due.
		rgmii_phy_pkg::frame_byte_t  hold;     // Receive: word whose high nibble is pending.
		rgmii_phy_pkg::rgmii_rx_t    rx;       // Receive beat on the pins.
		rgmii_phy_pkg::rgmii_tx_t    txp;      // Transmit beat as latched from the pins.
		logic                        tx_half;  // Transmit: low nibble of a slow byte is held.
		logic [3:0]                  tx_lo;    // Transmit: that low nibble.
		logic                        overrun;  // Sticky: a transmit byte found the queue full.
	} link_t;

	// All state on the core clock.
	typedef struct packed {
		logic                       ovr_s1;    // Overrun sync, first stage.
		logic                       ovr_s2;    // Overrun sync, second stage.
		rgmii_phy_pkg::line_pairs_t pin_s1;    // Line pin sync, first stage.
		rgmii_phy_pkg::line_pairs_t pin_s2;    // Line pin sync, second stage.
		rgmii_phy_pkg::frame_byte_t tx_word;   // Transmit byte handed to the core.
		logic                       tx_valid;  // It is a fresh byte.
		logic [3:0]                 tx_used;   // Pairs that carry transmit traffic.
		logic [3:0]                 rx_used;   // Pairs that carry receive traffic.
		rgmii_phy_pkg::line_pairs_t pair_out;  // Line wire levels.
		rgmii_phy_pkg::line_pairs_t oe_n;      // Line wire enables, low while driving.
		rgmii_phy_pkg::line_pairs_t rx_lines;  // Synced line levels of receiving pairs.
	} core_t;

	link_t                      lk_q;      // Link state.
	link_t                      lk_d;      // Its next value.
	core_t                      co_q;      // Core state.
	core_t                      co_d;      // Its next value.
	logic                       gig;       // Link side runs at gigabit.
	logic                       co_gig;    // Core side runs at gigabit.
	logic                       rxq_valid; // Receive word waiting on the link side.
	logic                       rxq_ready; // Link side takes a receive word.
	rgmii_phy_pkg::frame_byte_t rxq_data;  // That word.
	logic                       txq_push;  // Transmit byte complete on the link side.
	logic                       txq_ready; // Transmit queue has room.
	rgmii_phy_pkg::frame_byte_t txq_word;  // That byte.
	logic                       txq_valid; // Transmit byte waiting on the core side.
	rgmii_phy_pkg::frame_byte_t txq_data;  // That byte.

	// In-band status nibble shown on idle receive lines.
	function automatic logic [3:0] status_nibble(input rgmii_phy_pkg::line_status_t s);
		logic [3:0] n;
		n                                             = 4'h0;
		n[rgmii_phy_pkg::STAT_LINK_BIT]               = s.link_up;
		n[rgmii_phy_pkg::STAT_SPEED_LSB +: 2]         = s.speed;
		n[rgmii_phy_pkg::STAT_DUPLEX_BIT]             = s.full_duplex;
		return n;
	endfunction

	// One receive beat: clock high then low, valid on the rising half, valid XOR error on the falling.
	function automatic rgmii_phy_pkg::rgmii_rx_t drive_rx(input rgmii_phy_pkg::frame_byte_t w,
		input logic [3:0] lo, input logic [3:0] hi, input logic [3:0] idle);
		rgmii_phy_pkg::rgmii_rx_t r;
		r.clk_rise = 1'b1;
		r.clk_fall = 1'b0;
		r.ctl_rise = w.en;
		r.ctl_fall = w.en ^ w.err;
		r.d_rise   = (w.en || w.err) ? lo : idle;
		r.d_fall   = (w.en || w.err) ? hi : idle;
		return r;
	endfunction

	// Map one bit per pair onto each pair's positive wire and a second bit per pair onto its negative wire.
	function automatic rgmii_phy_pkg::line_pairs_t join_pairs(input logic [3:0] p, input logic [3:0] n);
		logic [7:0] v;
		v = 8'h00;
		for (int k = 0; k < 4; k++) begin
			v[7-2*k] = p[k];
			v[6-2*k] = n[k];
		end
		return rgmii_phy_pkg::line_pairs_t'(v);
	endfunction

	// Receive words travel from the core clock to the link clock; the core stalls on rx_in_ready.
	cdc_word_queue #(.WIDTH(WORD_W)) rx_queue (
		.wr_clk   (clk),
		.wr_rst   (srst),
		.wr_valid (rx_in_valid),
		.wr_ready (rx_in_ready),
		.wr_data  (rx_in),
		.rd_clk   (tx_clk),
		.rd_rst   (lk_q.rst_s2),
		.rd_valid (rxq_valid),
		.rd_ready (rxq_ready),
		.rd_data  (rxq_data)
	);

	// Transmit bytes travel from the link clock to the core clock; the MAC cannot be stalled.
	cdc_word_queue #(.WIDTH(WORD_W)) tx_queue (
		.wr_clk   (tx_clk),
		.wr_rst   (lk_q.rst_s2),
		.wr_valid (txq_push),
		.wr_ready (txq_ready),
		.wr_data  (txq_word),
		.rd_clk   (clk),
		.rd_rst   (srst),
		.rd_valid (txq_valid),
		.rd_ready (1'b1),
		.rd_data  (txq_data)
	);

	assign gig       = lk_q.stat_s2.speed == rgmii_phy_pkg::SPEED_1000;
	assign rxq_ready = gig || !lk_q.half;
	assign rgmii_rx  = lk_q.rx;

	// Link logic: receive beats out, transmit beats in, both on the MAC transmit clock.
	always_comb begin
		lk_d         = lk_q;
		lk_d.rst_s1  = srst;
		lk_d.rst_s2  = lk_q.rst_s1;
		lk_d.stat_s1 = line_status;
		lk_d.stat_s2 = lk_q.stat_s1;
		lk_d.txp     = rgmii_tx;
		// Receive side; a word with neither flag set shows as idle.
		if (gig) begin
			lk_d.half = 1'b0;
			if (rxq_valid) begin
				lk_d.rx = drive_rx(rxq_data, rxq_data.data[3:0], rxq_data.data[7:4],
					status_nibble(lk_q.stat_s2));
			end else begin
				lk_d.rx = drive_rx('0, 4'h0, 4'h0, status_nibble(lk_q.stat_s2));
			end
		end else if (lk_q.half) begin
			lk_d.half = 1'b0;
			lk_d.rx   = drive_rx(lk_q.hold, lk_q.hold.data[7:4], lk_q.hold.data[7:4],
				status_nibble(lk_q.stat_s2));
		end else if (rxq_valid) begin
			lk_d.half = 1'b1;
			lk_d.hold = rxq_data;
			lk_d.rx   = drive_rx(rxq_data, rxq_data.data[3:0], rxq_data.data[3:0],
				status_nibble(lk_q.stat_s2));
		end else begin
			lk_d.rx = drive_rx('0, 4'h0, 4'h0, status_nibble(lk_q.stat_s2));
		end
		// Transmit side: enable on the rising half, enable XOR error on the falling half.
		txq_push     = 1'b0;
		txq_word.en  = lk_q.txp.ctl_rise;
		txq_word.err = lk_q.txp.ctl_rise ^ lk_q.txp.ctl_fall;
		txq_word.data = {lk_q.txp.d_fall, lk_q.txp.d_rise};
		if (!(lk_q.txp.ctl_rise || lk_q.txp.ctl_fall)) begin
			lk_d.tx_half = 1'b0;
		end else if (gig) begin
			txq_push = 1'b1;
		end else if (!lk_q.tx_half) begin
			lk_d.tx_half = 1'b1;
			lk_d.tx_lo   = lk_q.txp.d_rise;
		end else begin
			lk_d.tx_half  = 1'b0;
			txq_word.data = {lk_q.txp.d_rise, lk_q.tx_lo};
			txq_push      = 1'b1;
		end
		// A byte lost for lack of room is flagged; the MAC has no way to wait.
		if (txq_push && !txq_ready) begin
			lk_d.overrun = 1'b1;
		end
		if (lk_q.rst_s2) begin
			lk_d        = '0;
			lk_d.rst_s1 = srst;
			lk_d.rst_s2 = lk_q.rst_s1;
			txq_push    = 1'b0;
		end
	end

	// Link registers.
	always_ff @(posedge tx_clk) begin
		lk_q <= lk_d;
	end

	assign co_gig = line_status.speed == rgmii_phy_pkg::SPEED_1000;

	// Core logic: pair roles per speed and crossover, line drive and sampled line levels.
	always_comb begin
		co_d          = co_q;
		co_d.ovr_s1   = lk_q.overrun;
		co_d.ovr_s2   = co_q.ovr_s1;
		co_d.pin_s1   = line_pair_in;
		co_d.pin_s2   = co_q.pin_s1;
		co_d.tx_word  = txq_data;
		co_d.tx_valid = txq_valid;
		if (co_gig) begin
			co_d.tx_used = 4'hF;
			co_d.rx_used = 4'hF;
		end else if (mdi_x) begin
			co_d.tx_used = 4'h2;
			co_d.rx_used = 4'h1;
		end else begin
			co_d.tx_used = 4'h1;
			co_d.rx_used = 4'h2;
		end
		// Only pairs with a transmit role are driven; slow speeds put one data bit per wire.
		co_d.pair_out = join_pairs(4'h0, 4'h0);
		if (txq_valid && (txq_data.en || txq_data.err)) begin
			co_d.pair_out = co_gig ? join_pairs(txq_data.data[3:0], txq_data.data[7:4]) :
				join_pairs(co_d.tx_used & {4{txq_data.data[0]}}, co_d.tx_used & {4{txq_data.data[4]}});
		end
		co_d.oe_n     = join_pairs(~co_d.tx_used, ~co_d.tx_used);
		// Mask with this cycle's roles, so a speed change never lets pairs C and D leak for one cycle.
		co_d.rx_lines = rgmii_phy_pkg::line_pairs_t'(co_q.pin_s2 & join_pairs(co_d.rx_used, co_d.rx_used));
		if (srst) begin
			co_d      = '0;
			co_d.oe_n = join_pairs(4'hF, 4'hF);
		end
	end

	// Core registers.
	always_ff @(posedge clk) begin
		co_q <= co_d;
	end

	assign tx_out         = co_q.tx_word;
	assign tx_out_valid   = co_q.tx_valid;
	assign tx_overrun     = co_q.ovr_s2;
	assign line_pair_out  = co_q.pair_out;
	assign line_pair_oe_n = co_q.oe_n;
	assign line_rx        = co_q.rx_lines;
	assign pair_tx_used   = co_q.tx_used;
	assign pair_rx_used   = co_q.rx_used;
	// Oscillator amplifier across the reference pins; the output always drives the inverted input.
	assign ref_osc_out    = ~ref_osc_in;

	// Receive clock is high in the first half and low in the second of every beat.
	a_rx_clk_shape: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		!lk_q.rst_s2 |=> lk_q.rx.clk_rise && !lk_q.rx.clk_fall)
		else $error("receive clock beat malformed");
	// A gigabit word appears split into nibbles with coded control one beat later.
	a_gig_rx_split: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		gig && rxq_valid && (rxq_data.en || rxq_data.err) |=> {lk_q.rx.d_fall, lk_q.rx.d_rise} ==
		$past(rxq_data.data) && lk_q.rx.ctl_rise == $past(rxq_data.en) &&
		lk_q.rx.ctl_fall == ($past(rxq_data.en) ^ $past(rxq_data.err)))
		else $error("gigabit receive word not split correctly");
	// While the control lines are idle, the data lines carry the status nibble on both edges.
	a_idle_status: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		$past(!lk_q.rst_s2) && !lk_q.rx.ctl_rise && !lk_q.rx.ctl_fall |->
		lk_q.rx.d_rise == status_nibble($past(lk_q.stat_s2)) && lk_q.rx.d_fall == lk_q.rx.d_rise)
		else $error("idle receive lines do not show status");
	// At slow speeds both halves of a receive beat carry one nibble; control still codes error on the falling half.
	a_slow_same_edges: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		$past(lk_q.stat_s2.speed) != rgmii_phy_pkg::SPEED_1000 |->
		lk_q.rx.d_rise == lk_q.rx.d_fall)
		else $error("slow receive beat halves differ");
	// At slow speeds a word goes out low nibble first, high nibble next beat.
	a_slow_nibble_pair: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		!gig && !lk_q.half && rxq_valid && (rxq_data.en || rxq_data.err) ##1 !gig |=>
		lk_q.rx.d_rise == $past(lk_q.hold.data[7:4]) && $past(lk_q.rx.d_rise) == $past(rxq_data.data[3:0], 2))
		else $error("slow receive nibble order wrong");
	// Gigabit transmit beats become bytes with the documented error coding.
	a_gig_tx_join: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		gig && $past(rgmii_tx.ctl_rise || rgmii_tx.ctl_fall) && $past(!lk_q.rst_s2) |->
		txq_push && txq_word.data == $past({rgmii_tx.d_fall, rgmii_tx.d_rise}) &&
		txq_word.err == $past(rgmii_tx.ctl_rise ^ rgmii_tx.ctl_fall))
		else $error("gigabit transmit byte mis-joined");
	// Slow transmit bytes pair two beats, low nibble first.
	a_slow_tx_join: assert property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		!gig && !lk_q.tx_half && lk_q.txp.ctl_rise ##1 !gig && lk_q.txp.ctl_rise |->
		txq_push && txq_word.data == {lk_q.txp.d_rise, $past(lk_q.txp.d_rise)})
		else $error("slow transmit byte mis-joined");
	// Slow speeds: pairs C and D are released and silent.
	a_unused_pairs: assert property (@(posedge clk) disable iff (srst)
		!co_gig |=> co_q.oe_n[3:0] == 4'hF && co_q.pair_out[3:0] == 4'h0 && co_q.rx_lines[3:0] == 4'h0)
		else $error("pairs C or D active at slow speed");
	// Slow speeds: pair A transmits in straight mode and receives in crossover.
	a_pair_a_role: assert property (@(posedge clk) disable iff (srst)
		!co_gig |=> pair_tx_used[0] == !$past(mdi_x) && pair_rx_used[0] == $past(mdi_x))
		else $error("pair A role wrong");
	// Slow speeds: pair B receives in straight mode and transmits in crossover.
	a_pair_b_role: assert property (@(posedge clk) disable iff (srst)
		!co_gig |=> pair_tx_used[1] == $past(mdi_x) && pair_rx_used[1] == !$past(mdi_x))
		else $error("pair B role wrong");
	// Gigabit: every pair both drives and receives.
	a_gig_all_pairs: assert property (@(posedge clk) disable iff (srst)
		co_gig |=> pair_tx_used == 4'hF && pair_rx_used == 4'hF && line_pair_oe_n == 8'h00)
		else $error("gigabit pair not bidirectional");

	// Main scenarios.
	c_gig_rx_word: cover property (@(posedge tx_clk) disable iff (lk_q.rst_s2) gig && rxq_valid ##1 gig && rxq_valid);
	c_slow_rx_word: cover property (@(posedge tx_clk) disable iff (lk_q.rst_s2) !gig && lk_q.half);
	c_slow_tx_byte: cover property (@(posedge tx_clk) disable iff (lk_q.rst_s2) !gig && txq_push);
	c_idle_link_up: cover property (@(posedge tx_clk) disable iff (lk_q.rst_s2)
		!lk_q.rx.ctl_rise && lk_q.rx.d_rise[rgmii_phy_pkg::STAT_LINK_BIT]);
	c_crossover: cover property (@(posedge clk) disable iff (srst) !co_gig && mdi_x ##1 txq_valid);
endmodule

// File: include/rgmii_phy_pkg.sv
// Shared constants and carrier types for the PHY-side RGMII data port and line pair map.
// Operation
// - PHY drives receive clock, times data to it.
// - PHY delivers received data on four lines.
// - Idle receive lines carry speed, duplex, link.
// - PHY codes valid and error on one line.
// - Slow speeds: pair A transmits MDI, receives MDI-X.
// - Slow speeds: pair B receives MDI, transmits MDI-X.
// - Slow speeds: pairs C and D stay unused.
// - Gigabit: all four pairs carry both directions.
// - Reference timing from a 25 MHz source.
package rgmii_phy_pkg;

	// Speed codes as they appear in the in-band status nibble.
	localparam logic [1:0] SPEED_10   = 2'h0;
	localparam logic [1:0] SPEED_100  = 2'h1;
	localparam logic [1:0] SPEED_1000 = 2'h2;

	// Bit positions inside the in-band status nibble.
	localparam int STAT_LINK_BIT   = 0;
	localparam int STAT_SPEED_LSB  = 1;
	localparam int STAT_DUPLEX_BIT = 3;

	// Link clock rates per speed, in kHz; the MAC transmit clock and the receive clock share them.
	localparam int LINK_CLK_1000_KHZ = 125000;
	localparam int LINK_CLK_100_KHZ  = 25000;
	localparam int LINK_CLK_10_KHZ   = 2500;

	// Core clock and reference source rates, in kHz, and reference tolerance in ppm.
	localparam int CORE_CLK_KHZ = 200000;
	localparam int REF_OSC_KHZ  = 25000;
	localparam int REF_OSC_PPM  = 50;

	// Address width of the crossing queues; must be at least two.
	localparam int CDC_ADDR_W = 2;

	// One RGMII transmit beat: both edges of one MAC transmit clock cycle.
	typedef struct packed {
		logic [3:0] d_rise;
		logic [3:0] d_fall;
		logic       ctl_rise;
		logic       ctl_fall;
	} rgmii_tx_t;

	// One RGMII receive beat, including the level of the receive clock in each half.
	typedef struct packed {
		logic       clk_rise;
		logic       clk_fall;
		logic [3:0] d_rise;
		logic [3:0] d_fall;
		logic       ctl_rise;
		logic       ctl_fall;
	} rgmii_rx_t;

	// One frame byte with its enable (or valid) and error flags.
	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic       err;
	} frame_byte_t;

	// Line state reported by the core.
	typedef struct packed {
		logic [1:0] speed;
		logic       full_duplex;
		logic       link_up;
	} line_status_t;

	// The eight wires of the four line pairs.
	typedef struct packed {
		logic line_pair_a_pos;
		logic line_pair_a_neg;
		logic line_pair_b_pos;
		logic line_pair_b_neg;
		logic line_pair_c_pos;
		logic line_pair_c_neg;
		logic line_pair_d_pos;
		logic line_pair_d_neg;
	} line_pairs_t;

endpackage

// File: test/mac_model.sv
// Behavioural MAC that drives RGMII transmit beats toward the port.
`timescale 1ns/1ps
module mac_model (
	input  wire logic                tx_clk,
	output rgmii_phy_pkg::rgmii_tx_t rgmii_tx
);
	// The lines start idle; every beat follows the MAC's own transmit clock.
	initial rgmii_tx = '0;
	// Sends one byte; gigabit splits the nibbles over the edges, slow speeds repeat each nibble.
	task automatic send_byte(input logic [7:0] data, input logic err, input logic gig);
		@(posedge tx_clk);
		if (gig) begin
			rgmii_tx <= '{data[3:0], data[7:4], 1'b1, ~err};
		end else begin
			rgmii_tx <= '{data[3:0], data[3:0], 1'b1, ~err};
			@(posedge tx_clk);
			rgmii_tx <= '{data[7:4], data[7:4], 1'b1, ~err};
		end
		@(posedge tx_clk);
		// Idle data lines flip, so a stale nibble is never mistaken for data.
		rgmii_tx <= '{~data[3:0], ~data[7:4], 1'b0, 1'b0};
	endtask
endmodule

// File: test/rgmii_phy_port_tb_top.sv
// Self-checking bench for the RGMII port: pair map, in-band status and both data paths.
`timescale 1ns/1ps
module rgmii_phy_port_tb_top;
	logic                        clk = 1'b0;          // Core clock, 200 MHz.
	logic                        tx_clk = 1'b0;       // MAC transmit clock, 6 ns period.
	logic                        srst = 1'b1;         // Synchronous reset, held at the start.
	logic                        mdi_x = 1'b0;        // Crossover select.
	logic                        rx_in_valid = 1'b0;  // Receive word offered to the port.
	logic                        ref_osc_in = 1'b0;   // Reference oscillator, 25 MHz.
	rgmii_phy_pkg::line_status_t line_status = '0;    // Speed, duplex and link.
	rgmii_phy_pkg::frame_byte_t  rx_in = '0;          // Word headed for the MAC.
	rgmii_phy_pkg::line_pairs_t  line_pair_in = 8'hA5; // Fixed wire levels.
	rgmii_phy_pkg::rgmii_tx_t    rgmii_tx;            // Beats from the MAC model.
	rgmii_phy_pkg::rgmii_rx_t    rgmii_rx;            // Beats toward the MAC.
	rgmii_phy_pkg::frame_byte_t  tx_out;              // Decoded transmit byte.
	rgmii_phy_pkg::line_pairs_t  line_pair_out, line_pair_oe_n, line_rx;
	logic                        rx_in_ready, tx_out_valid, tx_overrun, ref_osc_out;
	logic [3:0]                  pair_tx_used, pair_rx_used;
	int                          failures = 0;
	int                          num_checks = 0;
	// Clocks: the link clock starts off phase so no edge meets a core edge.
	initial forever #2.5 clk = ~clk;
	initial begin
		#1.3;
		forever #3 tx_clk = ~tx_clk;
	end
	initial forever #20 ref_osc_in = ~ref_osc_in;
	rgmii_phy_port dut_u (.clk(clk), .srst(srst), .tx_clk(tx_clk), .rgmii_tx(rgmii_tx), .rgmii_rx(rgmii_rx),
		.line_status(line_status), .mdi_x(mdi_x), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
		.rx_in_ready(rx_in_ready), .tx_out(tx_out), .tx_out_valid(tx_out_valid), .tx_overrun(tx_overrun),
		.line_pair_out(line_pair_out), .line_pair_oe_n(line_pair_oe_n), .line_pair_in(line_pair_in),
		.line_rx(line_rx), .pair_tx_used(pair_tx_used), .pair_rx_used(pair_rx_used),
		.ref_osc_in(ref_osc_in), .ref_osc_out(ref_osc_out));
	mac_model mac_u (.tx_clk(tx_clk), .rgmii_tx(rgmii_tx));
	// Verdict and end of run; the only place the run stops.
	task automatic end_sim();
		if (failures == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Counts one comparison and reports a mismatch at once.
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask
	// A wait that ran out of its bound counts as a mismatch.
	task automatic stall();
		failures++;
		end_sim();
	endtask
	// Every speed in both crossover settings: pair use, drivers and the idle status nibble.
	task automatic map_status();
		for (int s = 0; s < 3; s++) begin
			for (int m = 0; m < 2; m++) begin
				@(posedge clk);
				line_status <= '{s[1:0], m[0], 1'b1};
				mdi_x <= m[0];
				repeat (12) @(posedge tx_clk);
				#1;
				chk({pair_tx_used, pair_rx_used}, (s == 2) ? 16'hFF : (m ? 16'h21 : 16'h12));
				chk(line_pair_oe_n[3:0], (s == 2) ? 16'h0 : 16'hF);
				chk(line_rx, (s == 2) ? 16'hA5 : (m ? 16'h80 : 16'h20));
				chk(line_pair_out, 16'h0);
				chk({rgmii_rx.clk_rise, rgmii_rx.clk_fall}, 16'h2);
				chk({rgmii_rx.ctl_rise, rgmii_rx.ctl_fall, rgmii_rx.d_rise, rgmii_rx.d_fall},
					{6'h0, {2{m[0], s[1:0], 1'b1}}});
				chk(ref_osc_out, {~ref_osc_in});
			end
		end
	endtask
	// One word toward the MAC; the valid is held until the edge that sees ready high.
	task automatic rx_word(input logic [7:0] data, input logic err, input logic gig);
		@(posedge clk);
		line_status <= '{gig ? 2'h2 : 2'h1, 1'b1, 1'b1};
		repeat (20) @(posedge clk);
		rx_in <= '{data, 1'b1, err};
		rx_in_valid <= 1'b1;
		for (int i = 0; i <= 20; i++) begin
			@(negedge clk);
			if (rx_in_ready) break;
			if (i == 20) stall();
		end
		@(posedge clk);
		rx_in_valid <= 1'b0;
		for (int i = 0; i <= 30; i++) begin
			@(posedge tx_clk);
			#1;
			if (rgmii_rx.ctl_rise) break;
			if (i == 30) stall();
		end
		chk({rgmii_rx.d_fall, rgmii_rx.d_rise, rgmii_rx.ctl_fall},
			gig ? {data, ~err} : {data[3:0], data[3:0], ~err});
		if (!gig) begin
			@(posedge tx_clk);
			#1;
			chk({rgmii_rx.d_fall, rgmii_rx.d_rise, rgmii_rx.ctl_rise}, {data[7:4], data[7:4], 1'b1});
		end
	endtask
	// One byte from the MAC model; the decoded byte must come out whole, nothing dropped.
	task automatic tx_byte(input logic [7:0] data, input logic err, input logic gig, input logic [7:0] pairs);
		mac_u.send_byte(data, err, gig);
		for (int i = 0; i <= 40; i++) begin
			@(negedge clk);
			if (tx_out_valid) break;
			if (i == 40) stall();
		end
		chk({tx_out, tx_overrun}, {data, 1'b1, err, 1'b0});
		chk(line_pair_out, pairs);
	endtask
	// Main sequence: reset for eight cycles, then each scenario in turn.
	initial begin
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (8) @(posedge clk);
		map_status();
		rx_word(8'h3C, 1'b0, 1'b1);
		// Wire levels: gigabit pair k carries bit k and bit k+4; crossover at slow speed drives pair B only.
		tx_byte(8'hA7, 1'b0, 1'b1, 8'hB9);
		tx_byte(8'h5E, 1'b1, 1'b1, 8'h6E);
		rx_word(8'hC5, 1'b1, 1'b0);
		tx_byte(8'h96, 1'b0, 1'b0, 8'h10);
		end_sim();
	end
endmodule
